//--- bench/prog_link_assertions.sv
`timescale 1ns/1ns
module prog_link_checker (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic prog_reset_pin_n,
    input wire logic prog_link_clock,
    input wire logic prog_link_data_out,
    input wire logic prog_link_data_oe_n,
    input wire logic nvm_enable_bit,
    input wire logic rx_strobe,
    input wire logic parity_error,
    input wire logic frame_error,
    input wire logic break_seen,
    input wire logic collision,
    input wire logic error_state,
    input wire logic link_active
);
    wire exc = parity_error | frame_error | break_seen | collision;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    AST_RELEASE_AFTER_ONE: assert property ($rose(prog_link_data_oe_n) |-> $past(prog_link_data_out))
        else $error("driver released after a zero");
    AST_STROBE_CLEAN: assert property (rx_strobe |-> !(parity_error | frame_error | break_seen))
        else $error("good byte with an exception");
    AST_STROBE_STATE: assert property (rx_strobe |-> !error_state && link_active)
        else $error("byte presented in error or when off");
    AST_EXC_SETS_ERR: assert property (parity_error | frame_error | collision |-> ##[0:1] error_state)
        else $error("exception left error state clear");
    AST_ERR_CAUSE: assert property ($rose(error_state) |-> exc || $past(exc))
        else $error("error state without an exception");
    AST_ERR_CLEAR: assert property ($fell(error_state) |-> break_seen || $past(break_seen))
        else $error("error state left without a break");
    AST_COLL_HOLD: assert property (collision |-> prog_link_data_oe_n [*8])
        else $error("driver on after collision");
    AST_LINK_PIN: assert property ($rose(link_active) |-> !prog_reset_pin_n)
        else $error("link on with pin high");
    AST_LINK_DROP: assert property ($fell(link_active) |-> !nvm_enable_bit && prog_reset_pin_n)
        else $error("link dropped wrongly");
    AST_FALL_EDGE: assert property ($changed(prog_link_data_oe_n) |-> !$past(prog_link_clock, 2))
        else $error("driver moved off a clock fall");
endmodule : prog_link_checker

bind serial_programming_phy prog_link_checker u_chk (
    .clock, .reset_n, .prog_reset_pin_n, .prog_link_clock, .prog_link_data_out,
    .prog_link_data_oe_n, .nvm_enable_bit, .rx_strobe, .parity_error, .frame_error,
    .break_seen, .collision, .error_state, .link_active
);

//--- bench/prog_model.sv
`timescale 1ns/1ns
module prog_model (
    output logic prog_link_clock,
    output logic pull_low,
    input wire logic line,
    output logic [23:0] got
);
    initial begin
        prog_link_clock = 1'b0;
        pull_low = 1'b0;
        got = 24'h000000;
    end

    // The clock rests low between calls, so data only moves while it is low.
    task automatic ticks(input int n, input logic low);
        repeat (n) begin
            pull_low = low;
            #32 prog_link_clock = 1'b1;
            #32 prog_link_clock = 1'b0;
        end
    endtask : ticks

    task automatic send(input logic [7:0] b, input logic bad_par, input logic bad_stop);
        logic [10:0] f;
        f = {1'b1, !bad_stop, ^b ^ bad_par, b};
        ticks(1, 1'b1);
        for (int i = 0; i < 11; i++) ticks(1, !f[i]);
        ticks(1, 1'b0);
    endtask : send

    // A hit index pulls that bit low to force a clash with a released line.
    task automatic listen(input int hit);
        logic [10:0] f;
        int idle;
        int i;
        f = 11'h000;
        idle = 0;
        i = -1;
        while (i < 11 && idle < 400) begin
            #32 prog_link_clock = 1'b1;
            if (i >= 0) f[i] = line;
            if (i >= 0 || !line) i++;
            else idle++;
            #32 prog_link_clock = 1'b0;
            pull_low = (hit >= 0) && (i == hit);
        end
        pull_low = 1'b0;
        got = {3'b010, !got[20], 9'(idle), f};
    endtask : listen
endmodule : prog_model

//--- bench/tb.sv
`timescale 1ns/1ns
module tb;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic prog_reset_pin_n = 1'b0;
    logic nvm_enable_bit = 1'b0;
    logic tx_mode = 1'b0;
    logic guard_load = 1'b0;
    logic [7:0] guard_time = 8'h00;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic [7:0] rx_byte, g;
    logic [7:0] tb_b[8];
    logic [23:0] got;
    logic [23:0] expq[$];
    logic prog_link_clock, pull_low, line, prog_link_data_out, prog_link_data_oe_n;
    logic tx_ready, rx_strobe, parity_error, frame_error, break_seen, collision;
    logic error_state, link_active;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    integer seed = 32'hed25;

    serial_programming_phy u_dut (
        .clock, .reset_n, .prog_reset_pin_n, .prog_link_clock, .prog_link_data_in(line),
        .prog_link_data_out, .prog_link_data_oe_n, .nvm_enable_bit, .tx_mode, .guard_load,
        .guard_time, .tx_valid, .tx_data, .tx_ready, .rx_byte, .rx_strobe, .parity_error,
        .frame_error, .break_seen, .collision, .error_state, .link_active
    );
    prog_model u_prog (.prog_link_clock, .pull_low, .line, .got);

    // Pull-up on the pin; a zero from either side wins a clash.
    assign line = (prog_link_data_oe_n | prog_link_data_out) & !pull_low;

    always #4 clock = !clock;

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic pop(input logic [23:0] seen);
        if (expq.size() == 0) check(seen, 24'h000000);
        else check(seen, expq.pop_front());
    endtask : pop

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    task automatic frame(input logic [7:0] b, input logic bp, input logic bs, input logic [4:0] fl);
        expq.push_back({3'b001, 8'h00, fl, fl[4] ? b : 8'h00});
        u_prog.send(b, bp, bs);
    endtask : frame

    task automatic brk;
        expq.push_back({3'b001, 8'h00, 5'h02, 8'h00});
        u_prog.ticks(12, 1'b1);
        u_prog.ticks(1, 1'b0);
    endtask : brk

    task automatic wrap_up;
        check(24'(expq.size()), 24'h000000);
        if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up

    // Outputs move on the rising edge, so they are read half a cycle later to avoid a race.
    always @(negedge clock) begin
        cycles++;
        if ({rx_strobe, parity_error, frame_error, break_seen, collision} !== 5'h00)
            pop({3'b001, 8'h00, rx_strobe, parity_error, frame_error, break_seen, collision,
                rx_strobe ? rx_byte : 8'h00});
        if (cycles == 20000) begin
            mismatches++;
            wrap_up;
        end
    end
    always @(got) if (got[23:21] == 3'b010) pop({got[23:21], 1'b0, got[19:0]});

    initial begin
        cyc(4);
        reset_n = 1'b1;
        u_prog.ticks(15, 1'b0);
        cyc(20);
        check({23'h0, link_active}, 24'h000000);
        u_prog.ticks(1, 1'b0);
        cyc(10);
        check({23'h0, link_active}, 24'h000001);
        brk();
        brk();
        for (int i = 0; i < 4; i++) frame(8'($random(seed)), 1'b0, 1'b0, 5'h10);
        frame(8'h00, 1'b0, 1'b1, 5'h04);
        check({23'h0, error_state}, 24'h000001);
        u_prog.send(8'h5a, 1'b0, 1'b0);
        brk();
        check({23'h0, error_state}, 24'h000000);
        frame(8'($random(seed)), 1'b1, 1'b0, 5'h08);
        brk();
        // Nothing drains while receiving, so the ninth byte must be refused.
        for (int i = 0; i < 8; i++) begin
            tb_b[i] = 8'($random(seed));
            tx_data = tb_b[i];
            tx_valid = 1'b1;
            cyc(1);
        end
        tx_data = 8'h3c;
        cyc(3);
        check({23'h0, tx_ready}, 24'h000000);
        tx_valid = 1'b0;
        tx_mode = 1'b1;
        for (int i = 0; i < 8; i++) begin
            expq.push_back({4'b0100, (i == 0) ? 9'h083 : 9'h000, 2'b11, ^tb_b[i], tb_b[i]});
            u_prog.listen(-1);
            #200;
        end
        cyc(1);
        tx_mode = 1'b0;
        check({23'h0, tx_ready}, 24'h000001);
        g = 8'($random(seed));
        guard_time = g;
        guard_load = 1'b1;
        tx_data = 8'hff;
        tx_valid = 1'b1;
        cyc(1);
        guard_load = 1'b0;
        tx_valid = 1'b0;
        expq.push_back({3'b001, 8'h00, 5'h01, 8'h00});
        expq.push_back({4'b0100, {1'b0, g} + 9'h003, 11'h7f7});
        tx_mode = 1'b1;
        u_prog.listen(3);
        check({23'h0, error_state}, 24'h000001);
        cyc(1);
        tx_mode = 1'b0;
        u_prog.ticks(1, 1'b0);
        brk();
        frame(8'($random(seed)), 1'b0, 1'b0, 5'h10);
        nvm_enable_bit = 1'b1;
        prog_reset_pin_n = 1'b1;
        cyc(20);
        check({23'h0, link_active}, 24'h000001);
        // The pin is synchronised, so it must read low before the nvm bit may clear.
        prog_reset_pin_n = 1'b0;
        cyc(4);
        nvm_enable_bit = 1'b0;
        cyc(4);
        check({23'h0, link_active}, 24'h000001);
        prog_reset_pin_n = 1'b1;
        cyc(20);
        check({23'h0, link_active}, 24'h000000);
        wrap_up;
    end
endmodule : tb

//--- core/prog_link_pkg.sv
package prog_link_pkg;

    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;

    // Link clock rising edges with the data line high that enable the link.
    localparam logic [4:0] ENABLE_CYCLES = 5'h10;
    // A frame is start, eight data, parity and two stop bits.
    localparam logic [3:0] FRAME_BITS = 4'hc;
    // Bits shifted in after the start bit, up to the second stop bit.
    localparam logic [3:0] RX_BITS = 4'hb;
    localparam logic [3:0] BREAK_BITS = 4'hc;
    localparam int PAR_POS = 8;
    localparam int STOP1_POS = 9;
    localparam int STOP2_POS = 10;
    localparam logic [7:0] GUARD_DEFAULT = 8'h80;
    localparam logic [8:0] GUARD_EXTRA = 9'h002;

    typedef enum logic [0:0] {
        R_IDLE = 1'b0,
        R_FRAME = 1'b1
    } rx_state_t;

    typedef enum logic [1:0] {
        T_OFF = 2'b00,
        T_GUARD = 2'b01,
        T_HOLD = 2'b11,
        T_FRAME = 2'b10
    } tx_state_t;

endpackage : prog_link_pkg

//--- core/serial_programming_phy.sv
`timescale 1ns/1ns

module tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [CW-1:0] count;
        logic ready;
    } fifo_state_t;

    fifo_state_t q;
    fifo_state_t d;

    always_comb begin
        logic push;
        logic pop;
        push = in_valid & q.ready;
        pop = out_ready & (q.count != '0);
        d = q;
        if (push) begin
            d.mem[q.wptr] = in_data;
            d.wptr = (q.wptr == AW'(DEPTH - 1)) ? '0 : q.wptr + AW'(1);
        end
        if (pop) begin
            d.rptr = (q.rptr == AW'(DEPTH - 1)) ? '0 : q.rptr + AW'(1);
        end
        if (push && !pop) begin
            d.count = q.count + CW'(1);
        end else if (pop && !push) begin
            d.count = q.count - CW'(1);
        end
        // Ready is registered so the port never depends on the pop in the same cycle.
        d.ready = (d.count != CW'(DEPTH));
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign in_ready = q.ready;
    assign out_valid = (q.count != '0);
    assign out_data = q.mem[q.rptr];
endmodule : tx_fifo

module serial_programming_phy (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic prog_reset_pin_n,
    input wire logic prog_link_clock,
    input wire logic prog_link_data_in,
    output logic prog_link_data_out,
    output logic prog_link_data_oe_n,
    input wire logic nvm_enable_bit,
    input wire logic tx_mode,
    input wire logic guard_load,
    input wire logic [7:0] guard_time,
    input wire logic tx_valid,
    input wire logic [prog_link_pkg::DATA_W-1:0] tx_data,
    output logic tx_ready,
    output logic [prog_link_pkg::DATA_W-1:0] rx_byte,
    output logic rx_strobe,
    output logic parity_error,
    output logic frame_error,
    output logic break_seen,
    output logic collision,
    output logic error_state,
    output logic link_active
);
    import prog_link_pkg::*;

    typedef struct packed {
        logic [2:0] clk_s;
        logic [1:0] dat_s;
        logic [1:0] rst_s;
        logic active;
        logic [4:0] en_cnt;
        rx_state_t rx_st;
        logic [3:0] rx_cnt;
        logic [10:0] rx_sh;
        logic [3:0] low_run;
        logic wait_high;
        tx_state_t tx_st;
        logic [3:0] tx_cnt;
        logic [11:0] tx_sh;
        logic [8:0] g_cnt;
        logic prev_bit;
        logic [7:0] guard;
        logic err;
        logic dout;
        logic oe_n;
        logic [7:0] rx_byte;
        logic rx_strobe;
        logic parity_err;
        logic frame_err;
        logic break_seen;
        logic collision;
    } phy_state_t;

    phy_state_t q;
    phy_state_t d;
    logic pop;
    logic fifo_valid;
    logic [DATA_W-1:0] fifo_data;

    tx_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clock(clock),
        .reset_n(reset_n),
        .in_valid(tx_valid),
        .in_data(tx_data),
        .in_ready(tx_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(pop)
    );

    always_comb begin
        logic rise;
        logic fall;
        logic line;
        logic bit_out;
        rise = q.clk_s[1] & ~q.clk_s[2];
        fall = ~q.clk_s[1] & q.clk_s[2];
        line = q.dat_s[1];
        bit_out = 1'b1;
        d = q;
        pop = 1'b0;
        d.rx_strobe = 1'b0;
        d.parity_err = 1'b0;
        d.frame_err = 1'b0;
        d.break_seen = 1'b0;
        d.collision = 1'b0;
        // The third clock stage only feeds edge detection; stage one feeds stage two alone.
        d.clk_s = {q.clk_s[1:0], prog_link_clock};
        d.dat_s = {q.dat_s[0], prog_link_data_in};
        d.rst_s = {q.rst_s[0], prog_reset_pin_n};

        if (!q.active) begin
            d.oe_n = 1'b1;
            d.dout = 1'b1;
            d.tx_st = T_OFF;
            d.rx_st = R_IDLE;
            if (q.rst_s[1]) begin
                d.en_cnt = '0;
            end else if (rise) begin
                if (!line) begin
                    d.en_cnt = '0;
                end else if (q.en_cnt == ENABLE_CYCLES - 5'h01) begin
                    d.active = 1'b1;
                    d.en_cnt = '0;
                    d.err = 1'b0;
                    d.guard = GUARD_DEFAULT;
                    d.wait_high = 1'b0;
                    d.low_run = '0;
                    d.prev_bit = 1'b1;
                end else begin
                    d.en_cnt = q.en_cnt + 5'h01;
                end
            end
        end else if (q.rst_s[1] && !nvm_enable_bit) begin
            // With the nvm enable bit set, only power removal ends the session.
            d.active = 1'b0;
            d.oe_n = 1'b1;
            d.tx_st = T_OFF;
        end else begin
            if (guard_load) begin
                d.guard = guard_time;
            end

            if (q.tx_st == T_OFF && rise) begin
                if (line) begin
                    d.low_run = '0;
                    d.wait_high = 1'b0;
                end else if (q.low_run != BREAK_BITS) begin
                    d.low_run = q.low_run + 4'h1;
                end
                if (!line && q.low_run == BREAK_BITS - 4'h1) begin
                    // A break while in error recovers; any other break is an exception.
                    d.break_seen = 1'b1;
                    d.err = ~q.err;
                    d.wait_high = 1'b1;
                    d.rx_st = R_IDLE;
                end else begin
                    case (q.rx_st)
                        R_IDLE: begin
                            if (!line && !q.wait_high) begin
                                d.rx_st = R_FRAME;
                                d.rx_cnt = '0;
                            end
                        end
                        R_FRAME: begin
                            d.rx_sh = {line, q.rx_sh[10:1]};
                            d.rx_cnt = q.rx_cnt + 4'h1;
                            if (q.rx_cnt == RX_BITS - 4'h1) begin
                                d.rx_st = R_IDLE;
                                if (!d.rx_sh[STOP1_POS] || !d.rx_sh[STOP2_POS]) begin
                                    d.frame_err = 1'b1;
                                    d.err = 1'b1;
                                end
                                if ((^d.rx_sh[7:0]) != d.rx_sh[PAR_POS]) begin
                                    d.parity_err = 1'b1;
                                    d.err = 1'b1;
                                end
                                if (d.rx_sh[STOP1_POS] && d.rx_sh[STOP2_POS]
                                    && (^d.rx_sh[7:0]) == d.rx_sh[PAR_POS] && !q.err) begin
                                    d.rx_byte = d.rx_sh[7:0];
                                    d.rx_strobe = 1'b1;
                                end
                            end
                        end
                        default: d.rx_st = R_IDLE;
                    endcase
                end
            end

            case (q.tx_st)
                T_OFF: begin
                    if (tx_mode && !q.err && q.rx_st == R_IDLE) begin
                        d.tx_st = T_GUARD;
                        d.g_cnt = {1'b0, q.guard} + GUARD_EXTRA;
                        d.prev_bit = 1'b1;
                    end
                end
                T_GUARD: begin
                    if (!tx_mode) begin
                        d.tx_st = T_OFF;
                    end else if (fall) begin
                        d.g_cnt = q.g_cnt - 9'h001;
                        if (q.g_cnt == 9'h001) begin
                            d.tx_st = T_HOLD;
                        end
                    end
                end
                T_HOLD, T_FRAME: begin
                    if (q.tx_st == T_HOLD && !tx_mode) begin
                        d.tx_st = T_OFF;
                    end else if (fall) begin
                        if (q.tx_st == T_HOLD || q.tx_cnt == FRAME_BITS) begin
                            if (fifo_valid) begin
                                pop = 1'b1;
                                bit_out = 1'b0;
                                d.tx_sh = {1'b1, 2'b11, ^fifo_data, fifo_data};
                                d.tx_cnt = 4'h1;
                                d.tx_st = T_FRAME;
                            end else begin
                                d.tx_st = tx_mode ? T_HOLD : T_OFF;
                            end
                        end else begin
                            bit_out = q.tx_sh[0];
                            d.tx_sh = {1'b1, q.tx_sh[11:1]};
                            d.tx_cnt = q.tx_cnt + 4'h1;
                        end
                        d.dout = bit_out;
                        d.oe_n = ~(~bit_out | ~q.prev_bit);
                        d.prev_bit = bit_out;
                    end
                    // Zeros and the first one hide the line, so checking is only possible here.
                    if (rise && q.oe_n && !line) begin
                        d.collision = 1'b1;
                        d.err = 1'b1;
                        d.tx_st = T_OFF;
                    end
                end
                default: d.tx_st = T_OFF;
            endcase
            if (d.tx_st == T_OFF) begin
                d.oe_n = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
            q.oe_n <= 1'b1;
            q.dout <= 1'b1;
            q.prev_bit <= 1'b1;
            q.guard <= GUARD_DEFAULT;
        end else begin
            q <= d;
        end
    end

    assign prog_link_data_out = q.dout;
    assign prog_link_data_oe_n = q.oe_n;
    assign rx_byte = q.rx_byte;
    assign rx_strobe = q.rx_strobe;
    assign parity_error = q.parity_err;
    assign frame_error = q.frame_err;
    assign break_seen = q.break_seen;
    assign collision = q.collision;
    assign error_state = q.err;
    assign link_active = q.active;
endmodule : serial_programming_phy
